// ===== hw/itfm_pkg.sv
// package: register map, function codes and timing for the input terminal function mux
package itfm_pkg;
  localparam int unsigned NUM_TERM = 7;
  localparam logic [15:0] FC_LOW     = 16'h0000;
  localparam logic [15:0] FC_MID     = 16'h0001;
  localparam logic [15:0] FC_HIGH    = 16'h0002;
  localparam logic [15:0] FC_SECOND  = 16'h0003;
  localparam logic [15:0] FC_AU      = 16'h0004;
  localparam logic [15:0] FC_JOG     = 16'h0005;
  localparam logic [15:0] FC_THERMAL = 16'h0007;
  localparam logic [15:0] FC_EXT     = 16'h0008;
  localparam logic [15:0] FC_OPEN    = 16'h000A;
  localparam logic [15:0] FC_PANEL   = 16'h000C;
  localparam logic [15:0] FC_PID     = 16'h000E;
  localparam logic [15:0] FC_BRAKE   = 16'h000F;
  localparam logic [15:0] FC_PEXT    = 16'h0010;
  localparam logic [15:0] FC_VF      = 16'h0012;
  localparam logic [15:0] FC_STOP    = 16'h0018;
  localparam logic [15:0] FC_HOLD    = 16'h0019;
  localparam logic [15:0] FC_FWD     = 16'h003C;
  localparam logic [15:0] FC_REV     = 16'h003D;
  localparam logic [15:0] FC_RESET   = 16'h003E;
  localparam logic [15:0] FC_PNET    = 16'h0041;
  localparam logic [15:0] FC_ENET    = 16'h0042;
  localparam logic [15:0] FC_CSRC    = 16'h0043;
  localparam logic [15:0] FC_NONE    = 16'h270F;
  localparam logic [7:0] ADDR_SEL0   = 8'h00;
  localparam logic [7:0] ADDR_CFG    = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_ERR    = 8'h28;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [3:0] OPMODE_PANEL_IL = 4'h7;
  localparam logic [15:0] SEL_RESET [NUM_TERM] = '{FC_FWD, FC_REV, FC_LOW, FC_MID,
                                                    FC_HIGH, FC_STOP, FC_RESET};
  localparam int unsigned CLK_HZ    = 100_000_000;
  localparam int unsigned FAST_US   = 2000;
  localparam int unsigned SLOW_US   = 20000;
  localparam int unsigned FAST_CYC  = FAST_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SLOW_CYC  = SLOW_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FILT_CYC  = FAST_CYC / 4;
  typedef struct packed {
    logic forward_run_cmd;
    logic reverse_run_cmd;
    logic low_speed_sel;
    logic mid_speed_sel;
    logic high_speed_sel;
    logic extended_speed_sel;
    logic jog_sel;
    logic pid_valid_in;
    logic remote_clear;
    logic remote_decel;
    logic remote_accel;
    logic stop_contact_sel0;
    logic stop_contact_sel1;
    logic second_func_sel;
    logic analog_input_sel;
    logic ext_thermal_relay_in;
    logic operation_enable_in;
    logic panel_interlock_in;
    logic brake_open_done_in;
    logic panel_ext_switch_in;
    logic vf_switchover_in;
    logic output_stop_in;
    logic start_hold_sel;
    logic drive_reset_in;
    logic panel_net_switch_in;
    logic ext_net_switch_in;
    logic cmd_source_switch_in;
  } itfm_cmd_s;
  typedef enum logic [1:0] {ITFM_SPD_NONE, ITFM_SPD_JOG, ITFM_SPD_MULTI, ITFM_SPD_PID} itfm_spd_e;
endpackage

// ===== hw/itfm_top.sv
// input terminal function mux with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module itfm_top
  import itfm_pkg::*;
#(
  parameter int unsigned FAST_FILT = FILT_CYC,
  parameter int unsigned SLOW_FILT = SLOW_CYC / 4
)(
  input  wire logic              core_clk_in,
  input  wire logic              rstn_in,
  input  wire logic [6:0]        terminal_in,
  input  wire logic              motor_running_in,
  input  wire logic [11:0]       voltage_analog_in,
  input  wire logic [7:0]        s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [7:0]        s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  output itfm_cmd_s              cmd_out,
  output itfm_spd_e              speed_src_out,
  output logic                   vf_control_out,
  output logic [11:0]            voltage_analog_out
);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic code_allowed(input int unsigned t, input logic [15:0] c);
    logic ok;
    ok = c <= FC_JOG || c == FC_THERMAL || c == FC_EXT
      || c == FC_OPEN || c == FC_PANEL || (c >= FC_PID && c <= FC_PEXT)
      || c == FC_VF || c == FC_STOP || c == FC_HOLD || c == FC_RESET
      || (c >= FC_PNET && c <= FC_CSRC) || c == FC_NONE;
    if (t == 0 && c == FC_FWD)
      ok = 1'b1;
    if (t == 1 && c == FC_REV)
      ok = 1'b1;
    return ok;
  endfunction

  // ************************************************************
  // input synchronisers and response filters
  // ************************************************************
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  logic       run_s1_r;
  logic       run_s2_r;
  logic [6:0] term_r;
  logic [15:0] sel_r [NUM_TERM];

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sync1_r  <= '0;
      sync2_r  <= '0;
      run_s1_r <= 1'b0;
      run_s2_r <= 1'b0;
    end
    else
    begin
      sync1_r  <= terminal_in;
      sync2_r  <= sync1_r;
      run_s1_r <= motor_running_in;
      run_s2_r <= run_s1_r;
    end
  end

  // fast filter for enable/stop terminals, slow for the rest
  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++)
    begin : g_filt
      logic [31:0] cnt_r;
      logic        fast;
      assign fast = sel_r[g] == FC_OPEN || sel_r[g] == FC_STOP;
      always_ff @(posedge core_clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          cnt_r     <= '0;
          term_r[g] <= 1'b0;
        end
        else if (sync2_r[g] == term_r[g])
          cnt_r <= '0;
        else if (cnt_r >= (fast ? FAST_FILT : SLOW_FILT))
        begin
          cnt_r     <= '0;
          term_r[g] <= sync2_r[g];
        end
        else
          cnt_r <= cnt_r + 32'h0000_0001;
      end
    end
  endgenerate

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [1:0] remote_opt_r;
  logic       contact_opt_r;
  logic [3:0] opmode_r;
  logic       group_sel_r;
  logic       werr_r;

  // ************************************************************
  // function routing
  // ************************************************************
  itfm_cmd_s  c;
  logic [6:0] hit [0:67];
  logic       has_open;
  logic       has_panel;
  logic       remote_on;

  always_comb
  begin
    for (int k = 0; k <= 67; k++)
      for (int t = 0; t < NUM_TERM; t++)
        hit[k][t] = sel_r[t] == 16'(k) && term_r[t];
  end

  always_comb
  begin
    has_open  = 1'b0;
    has_panel = 1'b0;
    for (int t = 0; t < NUM_TERM; t++)
    begin
      has_open  = has_open  | (sel_r[t] == FC_OPEN);
      has_panel = has_panel | (sel_r[t] == FC_PANEL);
    end
    remote_on = remote_opt_r != 2'b00;
    c = '0;
    // shared terminals for speed and remote setting
    c.low_speed_sel   = |hit[0] && !remote_on && !contact_opt_r;
    c.mid_speed_sel   = |hit[1] && !remote_on;
    c.high_speed_sel  = |hit[2] && !remote_on;
    c.remote_clear    = |hit[0] && remote_on && !contact_opt_r;
    c.remote_decel    = |hit[1] && remote_on;
    c.remote_accel    = |hit[2] && remote_on;
    c.stop_contact_sel0 = |hit[0] && contact_opt_r;
    c.stop_contact_sel1 = |hit[3] && contact_opt_r;
    c.second_func_sel = (|hit[3] && !contact_opt_r) || |hit[18];
    c.analog_input_sel = |hit[4];
    c.jog_sel         = |hit[5];
    c.ext_thermal_relay_in = |(hit_open(7));
    c.extended_speed_sel = |hit[8];
    c.output_stop_in  = |hit[24];
    c.operation_enable_in = has_open ? |hit[10] : |hit[24];
    c.panel_interlock_in = (!has_panel && opmode_r == OPMODE_PANEL_IL) ? |hit[24]
                         : |hit[12];
    c.pid_valid_in    = |hit[14];
    c.brake_open_done_in = |hit[15];
    c.panel_ext_switch_in = |hit[16];
    c.vf_switchover_in = |hit[18];
    c.start_hold_sel  = |hit[25];
    c.forward_run_cmd = |hit[60];
    c.reverse_run_cmd = |hit[61];
    c.drive_reset_in  = |hit[62];
    c.panel_net_switch_in = |hit[65];
    c.ext_net_switch_in = |hit[66];
    c.cmd_source_switch_in = |hit[67];
  end

  // thermal relay asserts when the contact opens (terminal low)
  function automatic logic [6:0] hit_open(input int unsigned k);
    logic [6:0] h;
    for (int t = 0; t < NUM_TERM; t++)
      h[t] = sel_r[t] == 16'(k) && !term_r[t];
    return h;
  endfunction

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cmd_out       <= '0;
      speed_src_out <= ITFM_SPD_NONE;
    end
    else
    begin
      cmd_out <= c;
      if (c.jog_sel)
        speed_src_out <= ITFM_SPD_JOG;
      else if (c.high_speed_sel || c.mid_speed_sel || c.low_speed_sel || c.extended_speed_sel)
        speed_src_out <= ITFM_SPD_MULTI;
      else if (c.pid_valid_in)
        speed_src_out <= ITFM_SPD_PID;
      else
        speed_src_out <= ITFM_SPD_NONE;
    end
  end

  // control method changes only while stopped
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      vf_control_out <= 1'b0;
    else if (!run_s2_r)
      vf_control_out <= c.vf_switchover_in;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      voltage_analog_out <= '0;
    else
      voltage_analog_out <= c.analog_input_sel ? '0 : voltage_analog_in;
  end

  // ************************************************************
  // AXI4-Lite write
  // ************************************************************
  logic       aw_held_r;
  logic       w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic       do_write;
  logic [2:0] widx;
  logic       sel_hit;
  logic       w_ok;

  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid_out;
  assign widx     = awaddr_r[4:2];
  assign sel_hit  = awaddr_r < ADDR_CFG && widx < 3'(NUM_TERM) && awaddr_r[1:0] == 2'b00;
  assign w_ok     = (sel_hit && !group_sel_r && code_allowed(32'(widx), wdata_r[15:0]))
                 || awaddr_r == ADDR_CFG || awaddr_r == ADDR_ERR;

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      aw_held_r         <= 1'b0;
      w_held_r          <= 1'b0;
      awaddr_r          <= '0;
      wdata_r           <= '0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready_out <= !aw_held_r && !s_axi_awready_out && s_axi_awvalid_in;
      s_axi_wready_out  <= !w_held_r && !s_axi_wready_out && s_axi_wvalid_in;
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata_in;
      end
      if (do_write)
      begin
        aw_held_r        <= 1'b0;
        w_held_r         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int t = 0; t < NUM_TERM; t++)
        sel_r[t] <= SEL_RESET[t];
      remote_opt_r  <= '0;
      contact_opt_r <= 1'b0;
      opmode_r      <= '0;
      group_sel_r   <= 1'b0;
      werr_r        <= 1'b0;
    end
    else if (do_write)
    begin
      if (sel_hit && !group_sel_r && code_allowed(32'(widx), wdata_r[15:0]))
        sel_r[widx] <= wdata_r[15:0];
      if (sel_hit && !w_ok)
        werr_r <= 1'b1;
      else if (awaddr_r == ADDR_ERR)
        werr_r <= 1'b0;
      if (awaddr_r == ADDR_CFG)
      begin
        remote_opt_r  <= wdata_r[1:0];
        contact_opt_r <= wdata_r[4];
        opmode_r      <= wdata_r[11:8];
        group_sel_r   <= wdata_r[16];
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read
  // ************************************************************
  logic [31:0] rdata;
  logic [2:0]  ridx;
  logic        r_ok;

  assign ridx = s_axi_araddr_in[4:2];

  always_comb
  begin
    rdata = '0;
    r_ok  = 1'b1;
    if (s_axi_araddr_in < ADDR_CFG && ridx < 3'(NUM_TERM))
      rdata = {16'h0000, sel_r[ridx]};
    else if (s_axi_araddr_in == ADDR_CFG)
      rdata = {15'h0000, group_sel_r, 4'h0, opmode_r, 3'h0, contact_opt_r, 2'h0, remote_opt_r};
    else if (s_axi_araddr_in == ADDR_STATUS)
      rdata = {20'h00000, vf_control_out, 2'(speed_src_out), 2'h0, term_r};
    else if (s_axi_araddr_in == ADDR_ERR)
      rdata = {31'h0000_0000, werr_r};
    else
      r_ok = 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out && s_axi_arvalid_in;
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= rdata;
        s_axi_rresp_out  <= r_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule // itfm_top
`default_nettype wire

// ===== tb/itfm_top_monitor.sv
// checker for the input terminal function mux ports
`timescale 1ns/1ps
`default_nettype none
module itfm_top_monitor
  import itfm_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rstn_in,
  input wire logic        motor_running_in,
  input wire logic [11:0] voltage_analog_in,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [7:0]  s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire itfm_cmd_s   cmd_out,
  input wire itfm_spd_e   speed_src_out,
  input wire logic        vf_control_out,
  input wire logic [11:0] voltage_analog_out
);
  logic jog_w;
  logic multi_w;
  assign jog_w = cmd_out.jog_sel;
  assign multi_w = cmd_out.low_speed_sel | cmd_out.mid_speed_sel | cmd_out.high_speed_sel
                   | cmd_out.extended_speed_sel;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  b_answer_a: assert property (s_axi_wvalid_in && s_axi_wready_out |-> ##[1:4] s_axi_bvalid_out)
    else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped early");
  r_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
    && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
    else $error("read data unstable");
  rd_unmapped_a: assert property (s_axi_arvalid_in && s_axi_arready_out
    && s_axi_araddr_in > ADDR_ERR |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 32'h0)
    else $error("unmapped read not refused");
  analog_mask_a: assert property (cmd_out.analog_input_sel && $past(cmd_out.analog_input_sel)
    |-> voltage_analog_out == 12'h000)
    else $error("analog input not masked");
  analog_pass_a: assert property ($past(rstn_in) && !cmd_out.analog_input_sel
    && !$past(cmd_out.analog_input_sel) |-> voltage_analog_out == $past(voltage_analog_in))
    else $error("analog input not passed");
  prio_jog_a: assert property (jog_w && $past(jog_w) |-> speed_src_out == ITFM_SPD_JOG)
    else $error("jog not first");
  prio_multi_a: assert property (!jog_w && multi_w && $past(!jog_w && multi_w)
    |-> speed_src_out == ITFM_SPD_MULTI)
    else $error("multi speed not second");
  vf_second_a: assert property (cmd_out.vf_switchover_in && $past(cmd_out.vf_switchover_in)
    |-> cmd_out.second_func_sel)
    else $error("second set not selected with switchover");
  vf_freeze_a: assert property (motor_running_in [*5] |=> $stable(vf_control_out))
    else $error("control method changed while running");
endmodule // itfm_top_monitor
bind itfm_top itfm_top_monitor itfm_top_monitor_inst (.core_clk_in, .rstn_in, .motor_running_in,
  .voltage_analog_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .cmd_out, .speed_src_out, .vf_control_out,
  .voltage_analog_out);
`default_nettype wire

// ===== tb/itfm_contacts.sv
// model of the switches and relays wired to the terminals
`timescale 1ns/1ps
`default_nettype none
module itfm_contacts
(
  input  wire logic       core_clk_in,
  input  wire logic [6:0] closed_in,
  output logic      [6:0] terminal_out
);
  logic [6:0] last_r = 7'h00;
  logic [6:0] chg_r = 7'h00;
  logic [1:0] bounce_r = 2'h0;
  // a contact chatters for a few cycles after it moves
  always @(posedge core_clk_in)
  begin
    last_r <= closed_in;
    if (closed_in != last_r)
    begin
      chg_r <= closed_in ^ last_r;
      bounce_r <= 2'h3;
    end
    else if (bounce_r != 2'h0)
      bounce_r <= bounce_r - 2'h1;
  end
  assign terminal_out = closed_in ^ (bounce_r[0] ? chg_r : 7'h00);
endmodule // itfm_contacts
`default_nettype wire

// ===== tb/tb.sv
// testbench for the input terminal function mux
`timescale 1ns/1ps
`default_nettype none
module tb;
  import itfm_pkg::*;
  localparam logic [31:0] SLV = {30'h0, RESP_SLVERR};
  localparam logic [31:0] OKY = {30'h0, RESP_OKAY};
  localparam logic [7:0]  T6 = 8'h18;
  localparam logic [15:0] CODES [15] = '{FC_AU, FC_JOG, FC_EXT, FC_OPEN, FC_PANEL, FC_PID,
    FC_BRAKE, FC_PEXT, FC_VF, FC_STOP, FC_HOLD, FC_RESET, FC_PNET, FC_ENET, FC_CSRC};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        running = 1'b0;
  logic [6:0]  closed = 7'h00;
  logic [6:0]  term;
  logic [11:0] vin = 12'hABC;
  logic [11:0] vout;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, vf;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd, resp;
  itfm_cmd_s   cmd;
  itfm_spd_e   src;
  int          error_cnt = 0;
  int          num_checks = 0;
  always #5 clk = ~clk;
  itfm_contacts itfm_contacts_inst (.core_clk_in(clk), .closed_in(closed), .terminal_out(term));
  itfm_top #(.FAST_FILT(4), .SLOW_FILT(8)) itfm_top_inst (.core_clk_in(clk), .rstn_in(rstn),
    .terminal_in(term), .motor_running_in(running), .voltage_analog_in(vin),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .cmd_out(cmd), .speed_src_out(src),
    .vf_control_out(vf), .voltage_analog_out(vout));
  // ****************
  // bus and helpers
  // ****************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = {30'h0, bresp};
  endtask
  task rdr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    resp = {30'h0, rresp};
  endtask
  task st(input logic [6:0] c);
    @(posedge clk);
    closed <= c;
    repeat (40) @(posedge clk);
  endtask
  function automatic logic fld(input logic [15:0] c, input itfm_cmd_s m);
    case (c)
      FC_AU: return m.analog_input_sel;
      FC_JOG: return m.jog_sel;
      FC_EXT: return m.extended_speed_sel;
      FC_OPEN: return m.operation_enable_in;
      FC_PANEL: return m.panel_interlock_in;
      FC_PID: return m.pid_valid_in;
      FC_BRAKE: return m.brake_open_done_in;
      FC_PEXT: return m.panel_ext_switch_in;
      FC_VF: return m.vf_switchover_in;
      FC_STOP: return m.output_stop_in;
      FC_HOLD: return m.start_hold_sel;
      FC_RESET: return m.drive_reset_in;
      FC_PNET: return m.panel_net_switch_in;
      FC_ENET: return m.ext_net_switch_in;
      default: return m.cmd_source_switch_in;
    endcase
  endfunction
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task t_regs;
    for (int i = 0; i < 7; i++)
    begin
      rdr(8'(i * 4));
      chk("sel_init", {16'h0, SEL_RESET[i]}, rd);
    end
    rdr(8'h30);
    chk("unmapped", SLV, resp);
    wr(8'h08, {16'h0, FC_FWD});
    chk("fwd_code_low", SLV, resp);
    wr(T6, 32'h6);
    chk("code6", SLV, resp);
    rdr(ADDR_ERR);
    chk("err_flag", 32'h1, rd & 32'h1);
    wr(ADDR_CFG, 32'h0001_0000);
    wr(T6, {16'h0, FC_JOG});
    chk("locked", SLV, resp);
    wr(ADDR_CFG, 32'h0);
    rdr(T6);
    chk("locked_keep", {16'h0, FC_RESET}, rd);
    wr(T6, {16'h0, FC_NONE});
    chk("none_ok", OKY, resp);
    st(7'h40);
    chk("none_idle", 32'h0, {5'h0, cmd});
    chk("none_src", {30'h0, ITFM_SPD_NONE}, {30'h0, src});
    st(7'h00);
    wr(ADDR_ERR, 32'h0);
    rdr(ADDR_ERR);
    chk("err_clear", 32'h0, rd);
    $display("t_regs done");
  endtask
  task t_route;
    for (int k = 0; k < 15; k++)
    begin
      wr(T6, {16'h0, CODES[k]});
      st(7'h40);
      chk("route_on", 32'h1, {31'h0, fld(CODES[k], cmd)});
      st(7'h00);
      chk("route_off", 32'h0, {31'h0, fld(CODES[k], cmd)});
    end
    wr(T6, {16'h0, FC_THERMAL});
    st(7'h00);
    chk("thermal_open", 32'h1, {31'h0, cmd.ext_thermal_relay_in});
    st(7'h40);
    chk("thermal_shut", 32'h0, {31'h0, cmd.ext_thermal_relay_in});
    st(7'h03);
    chk("fwd_rev", 32'h3, {30'h0, cmd.forward_run_cmd, cmd.reverse_run_cmd});
    wr(T6, {16'h0, FC_STOP});
    st(7'h20);
    chk("stop_enable", 32'h1, {31'h0, cmd.operation_enable_in});
    st(7'h40);
    chk("stop_or", 32'h1, {31'h0, cmd.output_stop_in});
    wr(ADDR_CFG, 32'h0000_0700);
    st(7'h40);
    chk("stop_interlock", 32'h1, {31'h0, cmd.panel_interlock_in});
    wr(T6, {16'h0, FC_OPEN});
    st(7'h20);
    chk("enable_own", 32'h0, {31'h0, cmd.operation_enable_in});
    wr(ADDR_CFG, 32'h0);
    $display("t_route done");
  endtask
  task t_remap;
    wr(ADDR_CFG, 32'h1);
    st(7'h04);
    chk("remote_clear", 32'h2, {30'h0, cmd.remote_clear, cmd.low_speed_sel});
    wr(ADDR_CFG, 32'h2);
    st(7'h18);
    chk("remote_updn", 32'h6, {29'h0, cmd.remote_decel, cmd.remote_accel, cmd.mid_speed_sel});
    wr(ADDR_CFG, 32'h10);
    st(7'h04);
    chk("contact_sel0", 32'h1, {31'h0, cmd.stop_contact_sel0});
    wr(T6, {16'h0, FC_SECOND});
    st(7'h40);
    chk("contact_sel1", 32'h2, {30'h0, cmd.stop_contact_sel1, cmd.second_func_sel});
    wr(ADDR_CFG, 32'h0);
    st(7'h40);
    chk("second_back", 32'h1, {31'h0, cmd.second_func_sel});
    $display("t_remap done");
  endtask
  task t_prio;
    wr(T6, {16'h0, FC_JOG});
    st(7'h50);
    chk("prio_jog", {30'h0, ITFM_SPD_JOG}, {30'h0, src});
    st(7'h10);
    chk("prio_multi", {30'h0, ITFM_SPD_MULTI}, {30'h0, src});
    wr(T6, {16'h0, FC_PID});
    st(7'h40);
    chk("prio_pid", {30'h0, ITFM_SPD_PID}, {30'h0, src});
    st(7'h44);
    chk("prio_over_pid", {30'h0, ITFM_SPD_MULTI}, {30'h0, src});
    $display("t_prio done");
  endtask
  task t_vf;
    wr(T6, {16'h0, FC_VF});
    st(7'h40);
    chk("vf_on", 32'h3, {30'h0, vf, cmd.second_func_sel});
    rdr(ADDR_STATUS);
    chk("status", 32'h0000_0840, rd);
    running <= 1'b1;
    st(7'h00);
    chk("vf_frozen", 32'h2, {30'h0, vf, cmd.second_func_sel});
    running <= 1'b0;
    st(7'h00);
    chk("vf_off", 32'h0, {31'h0, vf});
    wr(T6, {16'h0, FC_AU});
    st(7'h40);
    chk("au_mask", 32'h0, {20'h0, vout});
    st(7'h00);
    chk("au_pass", 32'hABC, {20'h0, vout});
    $display("t_vf done");
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("BAD watchdog exp done got hang");
    test_done;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_route;
    t_remap;
    t_prio;
    t_vf;
    test_done;
  end
endmodule // tb
`default_nettype wire
